// ===== hdl/fpu_exc_pkg.sv
package fpu_exc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRLW = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_TAG = 8'h0C;
  localparam logic [7:0] OFF_FIP = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int NATIVE_EN_BIT = 0;
  localparam int INV_MASK_BIT = 0;
  localparam int INV_FLAG_BIT = 0;
  localparam int STK_FAULT_BIT = 6;
  localparam int SUMMARY_BIT = 7;
  localparam int COND_ONE_BIT = 9;
  localparam int TOP_LSB = 11;
  localparam int CMD_INIT_BIT = 0;
  localparam logic NATIVE_EN_RST = 1'b0;
  localparam logic INV_MASK_RST = 1'b1;
  localparam logic [7:0] VEC_FLOAT_ERR = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int STACK_DEPTH = 8;
  localparam int PTR_W = 3;

  // ----------------------------------------------------------------
  // Instruction classes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    K_ARITH = 4'b0000,
    K_NONARITH = 4'b0001,
    K_LOAD_REG = 4'b0010,
    K_LOAD_EXT = 4'b0011,
    K_LOAD_CONST = 4'b0100,
    K_LOAD_CONV = 4'b0101,
    K_WAIT = 4'b0110,
    K_INIT_NW = 4'b0111,
    K_CLEX_NW = 4'b1000,
    K_STSW_NW = 4'b1001,
    K_STCW_NW = 4'b1010,
    K_STENV_NW = 4'b1011,
    K_SAVE_NW = 4'b1100
  } ins_kind_t;

  typedef enum logic [1:0] {
    IND_REAL = 2'b00,
    IND_INT = 2'b01,
    IND_BCD = 2'b10
  } indef_kind_t;

  function automatic logic is_nowait(input logic [3:0] k);
    return k inside {K_INIT_NW, K_CLEX_NW, K_STSW_NW, K_STCW_NW,
                     K_STENV_NW, K_SAVE_NW};
  endfunction

  function automatic logic is_arith(input logic [3:0] k);
    return k inside {K_ARITH, K_LOAD_CONV};
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    return a inside {OFF_CTRL0, OFF_CTRLW, OFF_STATUS, OFF_TAG,
                     OFF_FIP, OFF_CMD};
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

endpackage

// ===== hdl/unit_ifs.sv
interface reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
               input rd_data);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output rd_data);
endinterface

interface stack_if;
  logic push;
  logic pop;
  logic wr_top;
  logic rd_en;
  logic commit;
  logic init;
  logic [fpu_exc_pkg::PTR_W-1:0] rd_idx;
  logic overflow;
  logic underflow;
  logic [fpu_exc_pkg::PTR_W-1:0] top;
  logic [fpu_exc_pkg::STACK_DEPTH-1:0] tag;
  modport ctl (output push, pop, wr_top, rd_en, commit, init, rd_idx,
               input overflow, underflow, top, tag);
  modport stk (input push, pop, wr_top, rd_en, commit, init, rd_idx,
               output overflow, underflow, top, tag);
endinterface

// ===== hdl/reg_stack_tags.sv
module reg_stack_tags #(
  parameter int DEPTH = fpu_exc_pkg::STACK_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  stack_if.stk s
);
  localparam int PW = fpu_exc_pkg::PTR_W;
  logic [DEPTH-1:0] tag_reg;
  logic [PW-1:0] top_reg;
  logic [PW-1:0] push_slot;
  logic [PW-1:0] rd_slot;

  // Pointer arithmetic wraps modulo the depth
  assign push_slot = top_reg - 1'b1;
  assign rd_slot = top_reg + s.rd_idx;
  assign s.overflow = s.push & tag_reg[push_slot];
  assign s.underflow = s.rd_en & ~tag_reg[rd_slot];
  assign s.top = top_reg;
  assign s.tag = tag_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tag_reg <= '0;
      top_reg <= '0;
    end else if (s.init) begin
      tag_reg <= '0;
      top_reg <= '0;
    end else if (s.commit) begin
      if (s.push) begin
        tag_reg[push_slot] <= 1'b1;
        top_reg <= push_slot;
      end else if (s.pop) begin
        tag_reg[top_reg] <= 1'b0;
        top_reg <= top_reg + 1'b1;
      end else if (s.wr_top) begin
        tag_reg[top_reg] <= 1'b1;
      end
    end
  end
endmodule

// ===== hdl/bus_slave.sv
module bus_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  reg_if.bus rif
);
  logic aw_full_reg, w_full_reg, ar_full_reg, wr_go;
  logic [7:0] aw_addr_reg, ar_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // Address and data are held independently; the write fires once both
  assign wr_go = aw_full_reg & w_full_reg & ~bvalid;
  assign rif.wr_en = wr_go;
  assign rif.wr_addr = aw_addr_reg;
  assign rif.wr_data = w_data_reg;
  assign rif.wr_strb = w_strb_reg;
  assign rif.rd_addr = ar_addr_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b0;
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else begin
      awready <= awvalid & ~awready & ~aw_full_reg;
      if (awvalid & awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end else if (wr_go) begin
        aw_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wready <= 1'b0;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      wready <= wvalid & ~wready & ~w_full_reg;
      if (wvalid & wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end else if (wr_go) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= fpu_exc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= fpu_exc_pkg::reg_hit(aw_addr_reg) ?
               fpu_exc_pkg::RESP_OKAY : fpu_exc_pkg::RESP_SLVERR;
    end else if (bvalid & bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      ar_full_reg <= 1'b0;
      ar_addr_reg <= 8'h00;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= fpu_exc_pkg::RESP_OKAY;
    end else begin
      arready <= arvalid & ~arready & ~ar_full_reg & ~rvalid;
      if (arvalid & arready) begin
        ar_full_reg <= 1'b1;
        ar_addr_reg <= araddr;
      end else if (ar_full_reg & ~rvalid) begin
        ar_full_reg <= 1'b0;
        rvalid <= 1'b1;
        if (fpu_exc_pkg::reg_hit(ar_addr_reg)) begin
          rdata <= rif.rd_data;
          rresp <= fpu_exc_pkg::RESP_OKAY;
        end else begin
          rdata <= 32'h0000_0000;
          rresp <= fpu_exc_pkg::RESP_SLVERR;
        end
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== hdl/fpu_exc_unit.sv
module fpu_exc_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ins_valid,
  input wire logic [3:0] ins_kind,
  input wire logic ins_push,
  input wire logic ins_pop,
  input wire logic ins_wr_top,
  input wire logic ins_rd_en,
  input wire logic [2:0] ins_rd_idx,
  input wire logic ins_arith_invalid,
  input wire logic ins_cc_response,
  input wire logic [1:0] ins_dst_fmt,
  input wire logic [31:0] ins_ip,
  input wire logic ignore_numeric_error_n,
  output logic ins_done,
  output logic ins_trap,
  output logic [7:0] float_error_vector,
  output logic exec_halted,
  output logic float_error_out_n,
  output logic result_indefinite,
  output logic [1:0] indefinite_kind,
  output logic cond_unordered
);
  reg_if rif ();
  stack_if sif ();

  logic ign_meta_reg, ign_sync_reg;
  logic native_error_enable, invalid_mask, invalid_flag;
  logic stack_fault_flag, exception_summary_flag, condition_bit_one;
  logic pending_reg, pending_next;
  logic [31:0] fault_ip_reg;
  logic ignore_active, waiting, blocked, exec, trap_now, halt_now;
  logic ovf, unf, sfault, ia, inv, unmasked;
  logic sw_wr_status, sw_init, nw_clear, clr_inv, clr_stk, clr_sum;
  logic [31:0] clr_bits;
  logic [15:0] status_word;
  default disable iff (!rst_n);

  bus_slave u_bus (
    .clk(clk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rif(rif.bus)
  );

  reg_stack_tags #(.DEPTH(fpu_exc_pkg::STACK_DEPTH)) u_stack (
    .clk(clk), .rst_n(rst_n), .s(sif.stk)
  );

  // ----------------------------------------------------------------
  // Ignore-error pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ign_meta_reg <= 1'b1;
      ign_sync_reg <= 1'b1;
    end else begin
      ign_meta_reg <= ignore_numeric_error_n;
      ign_sync_reg <= ign_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Issue gate
  // ----------------------------------------------------------------
  // Native reporting overrides the pin completely
  assign ignore_active = ~native_error_enable & ~ign_sync_reg;
  assign waiting = ~fpu_exc_pkg::is_nowait(ins_kind);
  // A pending fault is only acted on at a waiting instruction
  assign blocked = ins_valid & ~exec_halted & waiting & pending_reg
                   & ~ignore_active;
  assign exec = ins_valid & ~exec_halted & ~blocked;
  assign trap_now = blocked & native_error_enable;
  assign halt_now = blocked & ~native_error_enable;

  // ----------------------------------------------------------------
  // Exception detection
  // ----------------------------------------------------------------
  assign sif.push = ins_push;
  assign sif.pop = ins_pop;
  assign sif.wr_top = ins_wr_top;
  assign sif.rd_en = ins_rd_en;
  assign sif.rd_idx = ins_rd_idx;
  assign ovf = exec & sif.overflow;
  assign unf = exec & sif.underflow;
  assign sfault = ovf | unf;
  // Plain loads never report operand faults
  assign ia = exec & ins_arith_invalid & ~sfault
              & fpu_exc_pkg::is_arith(ins_kind);
  assign inv = sfault | ia;
  assign unmasked = inv & ~invalid_mask;
  // Unmasked faults leave the stack pointer and operands alone
  assign sif.commit = exec & ~unmasked;
  assign sif.init = sw_init | (exec & (ins_kind == fpu_exc_pkg::K_INIT_NW));

  // ----------------------------------------------------------------
  // Software and instruction clears
  // ----------------------------------------------------------------
  assign sw_wr_status = rif.wr_en & (rif.wr_addr == fpu_exc_pkg::OFF_STATUS);
  assign sw_init = rif.wr_en & (rif.wr_addr == fpu_exc_pkg::OFF_CMD)
                   & rif.wr_strb[0] & rif.wr_data[fpu_exc_pkg::CMD_INIT_BIT];
  assign clr_bits = sw_wr_status ?
                    (rif.wr_data & fpu_exc_pkg::lane_mask(rif.wr_strb)) :
                    32'h0000_0000;
  assign nw_clear = sif.init
                    | (exec & (ins_kind == fpu_exc_pkg::K_CLEX_NW));
  assign clr_inv = nw_clear | clr_bits[fpu_exc_pkg::INV_FLAG_BIT];
  assign clr_stk = nw_clear | clr_bits[fpu_exc_pkg::STK_FAULT_BIT];
  assign clr_sum = nw_clear | clr_bits[fpu_exc_pkg::SUMMARY_BIT];

  // ----------------------------------------------------------------
  // Status flags (set wins over clear)
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      invalid_flag <= 1'b0;
      stack_fault_flag <= 1'b0;
      exception_summary_flag <= 1'b0;
    end else begin
      invalid_flag <= inv | (invalid_flag & ~clr_inv);
      // An operand fault does not touch the stack-fault flag
      stack_fault_flag <= sfault | (stack_fault_flag & ~clr_stk);
      exception_summary_flag <= inv
                                | (exception_summary_flag & ~clr_sum);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      condition_bit_one <= 1'b0;
    end else if (sfault) begin
      condition_bit_one <= ovf;
    end else if (sif.init | clr_bits[fpu_exc_pkg::COND_ONE_BIT]) begin
      condition_bit_one <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pending fault, error output and saved pointer
  // ----------------------------------------------------------------
  always_comb begin
    pending_next = pending_reg;
    if (unmasked) begin
      pending_next = 1'b1;
    end else if (clr_inv) begin
      pending_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= 1'b0;
      float_error_out_n <= 1'b1;
    end else begin
      pending_reg <= pending_next;
      // Feeds the external interrupt controller
      float_error_out_n <= ~pending_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_ip_reg <= 32'h0000_0000;
    end else if (unmasked) begin
      // Saved pointer is the faulting instruction's own ins_ip
      fault_ip_reg <= ins_ip;
    end
  end

  // ----------------------------------------------------------------
  // Instruction responses
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ins_done <= 1'b0;
      ins_trap <= 1'b0;
      float_error_vector <= 8'h00;
    end else begin
      ins_done <= exec;
      ins_trap <= trap_now;
      if (trap_now) begin
        float_error_vector <= fpu_exc_pkg::VEC_FLOAT_ERR;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_halted <= 1'b0;
    end else begin
      // Released when the interrupt handler clears the flags
      exec_halted <= halt_now | (exec_halted & pending_next);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_indefinite <= 1'b0;
      cond_unordered <= 1'b0;
      indefinite_kind <= fpu_exc_pkg::IND_REAL;
    end else begin
      result_indefinite <= inv & invalid_mask
                           & (sfault | ~ins_cc_response);
      cond_unordered <= ia & invalid_mask & ins_cc_response;
      if (inv) begin
        indefinite_kind <= ins_dst_fmt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software-written control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      native_error_enable <= fpu_exc_pkg::NATIVE_EN_RST;
    end else if (rif.wr_en & (rif.wr_addr == fpu_exc_pkg::OFF_CTRL0)
                 & rif.wr_strb[0]) begin
      native_error_enable <= rif.wr_data[fpu_exc_pkg::NATIVE_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      invalid_mask <= fpu_exc_pkg::INV_MASK_RST;
    end else if (sif.init) begin
      invalid_mask <= fpu_exc_pkg::INV_MASK_RST;
    end else if (rif.wr_en & (rif.wr_addr == fpu_exc_pkg::OFF_CTRLW)
                 & rif.wr_strb[0]) begin
      invalid_mask <= rif.wr_data[fpu_exc_pkg::INV_MASK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    status_word = 16'h0000;
    status_word[fpu_exc_pkg::INV_FLAG_BIT] = invalid_flag;
    status_word[fpu_exc_pkg::STK_FAULT_BIT] = stack_fault_flag;
    status_word[fpu_exc_pkg::SUMMARY_BIT] = exception_summary_flag;
    status_word[fpu_exc_pkg::COND_ONE_BIT] = condition_bit_one;
    status_word[fpu_exc_pkg::TOP_LSB +: fpu_exc_pkg::PTR_W] = sif.top;
  end

  always_comb begin
    rif.rd_data = 32'h0000_0000;
    unique case (rif.rd_addr)
      fpu_exc_pkg::OFF_CTRL0:
        rif.rd_data[fpu_exc_pkg::NATIVE_EN_BIT] = native_error_enable;
      fpu_exc_pkg::OFF_CTRLW:
        rif.rd_data[fpu_exc_pkg::INV_MASK_BIT] = invalid_mask;
      fpu_exc_pkg::OFF_STATUS: rif.rd_data[15:0] = status_word;
      fpu_exc_pkg::OFF_TAG: rif.rd_data[7:0] = sif.tag;
      fpu_exc_pkg::OFF_FIP: rif.rd_data = fault_ip_reg;
      default: rif.rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_wait_defers: assert property (@(posedge clk)
    blocked |=> !ins_done) else $error("waiting instruction ran");
  chk_nowait_runs: assert property (@(posedge clk)
    ins_valid && !exec_halted && !waiting |=> ins_done && !ins_trap)
    else $error("non-waiting instruction held");
  chk_load_class: assert property (@(posedge clk)
    exec && !sfault && ins_kind == fpu_exc_pkg::K_LOAD_REG
    && ins_arith_invalid |=> !invalid_flag || $past(invalid_flag))
    else $error("plain load faulted");
  chk_trap_vec: assert property (@(posedge clk) disable iff (!rst_n)
    blocked && native_error_enable |=> ins_trap && !ins_done
    && float_error_vector == 8'h10) else $error("no vector trap");
  chk_ignore_runs: assert property (@(posedge clk)
    ins_valid && !exec_halted && ignore_active |=> ins_done && !ins_trap)
    else $error("ignore mode stalled");
  chk_halt_stop: assert property (@(posedge clk)
    halt_now |=> exec_halted && !ins_done ##1 exec_halted || !pending_reg)
    else $error("halt not taken");
  chk_err_out: assert property (@(posedge clk) disable iff (!rst_n)
    unmasked |=> !float_error_out_n) else $error("error output late");
  chk_stack_flags: assert property (@(posedge clk)
    sfault |=> invalid_flag && stack_fault_flag
    && condition_bit_one == $past(ovf)) else $error("stack flags wrong");
  chk_fault_stale: assert property (@(posedge clk)
    stack_fault_flag && ia && !clr_stk |=> stack_fault_flag)
    else $error("stack-fault flag cleared");
  chk_top_hold: assert property (@(posedge clk) disable iff (!rst_n)
    unmasked && !sif.init |=> sif.top == $past(sif.top)
    && sif.tag == $past(sif.tag)) else $error("stack moved");
  chk_masked_indef: assert property (@(posedge clk)
    sfault && invalid_mask |=> result_indefinite)
    else $error("no indefinite result");
  chk_pending_hold: assert property (@(posedge clk)
    !float_error_out_n && !clr_inv |=> !float_error_out_n)
    else $error("error output dropped");
  chk_summary_set: assert property (@(posedge clk)
    inv |=> exception_summary_flag && invalid_flag)
    else $error("summary not set");
endmodule

// ===== sim/irq_ctrl_model.sv
module irq_ctrl_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic float_error_out_n,
  output logic irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // Level input: request follows the error line one edge late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) irq_req <= 1'b0;
    else irq_req <= !float_error_out_n;
  end
endmodule

// ===== sim/tb_fpu_exception_reporting.sv
module tb_fpu_exception_reporting;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ins_valid, ins_push, ins_pop;
  logic ins_wr_top, ins_rd_en, ins_arith_invalid, ins_cc_response;
  logic ignore_numeric_error_n, ins_done, ins_trap, exec_halted;
  logic float_error_out_n, result_indefinite, cond_unordered, irq_req;
  logic [7:0] awaddr, araddr, float_error_vector;
  logic [31:0] wdata, rdata, ins_ip, rd, fip;
  logic [3:0] wstrb, ins_kind;
  logic [1:0] bresp, rresp, ins_dst_fmt, indefinite_kind, rs, bs;
  logic [2:0] ins_rd_idx;
  int err_count, checked;
  fpu_exc_unit dut_u (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .ins_valid, .ins_kind,
    .ins_push, .ins_pop, .ins_wr_top, .ins_rd_en, .ins_rd_idx,
    .ins_arith_invalid, .ins_cc_response, .ins_dst_fmt, .ins_ip,
    .ignore_numeric_error_n, .ins_done, .ins_trap, .float_error_vector,
    .exec_halted, .float_error_out_n, .result_indefinite,
    .indefinite_kind, .cond_unordered);
  irq_ctrl_model irq_u (.clk, .rst_n, .float_error_out_n, .irq_req);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ------------------------------
  // Bus and instruction drivers
  // ------------------------------
  task chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (bvalid !== 1'b1) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bs = bresp;
    bready <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (rvalid !== 1'b1) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // Pushes ask for the decimal indefinite so the kind output is exercised
  task ins(input logic [3:0] k, input logic bad, push);
    @(posedge clk);
    ins_kind <= k;
    ins_arith_invalid <= bad;
    ins_push <= push;
    ins_dst_fmt <= {push, 1'b0};
    ins_ip <= ins_ip + 32'h0000_0004;
    ins_valid <= 1'b1;
    @(posedge clk);
    ins_valid <= 1'b0;
    #1;
  endtask
  task stack_overflow;
    rd_reg(fpu_exc_pkg::OFF_CTRLW);
    chk("mask_reset", rd & 32'h0000_0001, 32'h0000_0001);
    repeat (9) ins(fpu_exc_pkg::K_LOAD_EXT, 1'b0, 1'b1);
    chk("indefinite", {result_indefinite, indefinite_kind}, 3'h6);
    rd_reg(fpu_exc_pkg::OFF_STATUS);
    chk("status_ovf", rd & 32'h0000_02C1, 32'h0000_02C1);
    chk("masked_quiet", float_error_out_n, 1'b1);
    wr(fpu_exc_pkg::OFF_CMD, 32'h0000_0001);
  endtask
  task operand_rules;
    @(posedge clk);
    ins_cc_response <= 1'b1;
    ins(fpu_exc_pkg::K_LOAD_REG, 1'b1, 1'b0);
    rd_reg(fpu_exc_pkg::OFF_STATUS);
    chk("plain_load", rd & 32'h0000_0001, 32'h0000_0000);
    ins(fpu_exc_pkg::K_LOAD_CONV, 1'b1, 1'b0);
    chk("unordered", {cond_unordered, result_indefinite}, 2'h2);
    @(posedge clk);
    ins_cc_response <= 1'b0;
    ins_rd_en <= 1'b1;
    ins(fpu_exc_pkg::K_ARITH, 1'b0, 1'b0);
    chk("unf_indef", result_indefinite, 1'b1);
    @(posedge clk);
    ins_rd_en <= 1'b0;
    rd_reg(fpu_exc_pkg::OFF_STATUS);
    chk("status_unf", rd & 32'h0000_02C1, 32'h0000_00C1);
  endtask
  task native_trap;
    wr(fpu_exc_pkg::OFF_CTRLW, 32'h0000_0000);
    chk("wr_okay", bs, fpu_exc_pkg::RESP_OKAY);
    wr(fpu_exc_pkg::OFF_CTRL0, 32'h0000_0001);
    ins(fpu_exc_pkg::K_ARITH, 1'b1, 1'b0);
    fip = ins_ip;
    chk("err_out", {ins_done, float_error_out_n}, 2'h2);
    ins(fpu_exc_pkg::K_STSW_NW, 1'b0, 1'b0);
    chk("nowait", {ins_done, ins_trap, irq_req}, 3'h5);
    ins(fpu_exc_pkg::K_WAIT, 1'b0, 1'b0);
    chk("trap", {ins_trap, float_error_vector}, 9'h110);
    rd_reg(fpu_exc_pkg::OFF_FIP);
    chk("fault_ip", rd, fip);
    rd_reg(fpu_exc_pkg::OFF_STATUS);
    chk("summary", rd & 32'h0000_0081, 32'h0000_0081);
    chk("sf_stale", rd & 32'h0000_0040, 32'h0000_0040);
    wr(fpu_exc_pkg::OFF_STATUS, 32'h0000_0081);
    chk("cleared", float_error_out_n, 1'b1);
  endtask
  task halt_mode;
    wr(fpu_exc_pkg::OFF_CTRL0, 32'h0000_0000);
    ins(fpu_exc_pkg::K_ARITH, 1'b1, 1'b0);
    ins(fpu_exc_pkg::K_WAIT, 1'b0, 1'b0);
    chk("halt", {exec_halted, ins_done}, 2'h2);
    wr(fpu_exc_pkg::OFF_STATUS, 32'h0000_0001);
    chk("resume", exec_halted, 1'b0);
  endtask
  task ignore_mode;
    @(posedge clk);
    ignore_numeric_error_n <= 1'b0;
    ins(fpu_exc_pkg::K_ARITH, 1'b1, 1'b0);
    ins(fpu_exc_pkg::K_WAIT, 1'b0, 1'b0);
    chk("ignore", {exec_halted, ins_trap, ins_done}, 3'h1);
    chk("err_kept", float_error_out_n, 1'b0);
    wr(fpu_exc_pkg::OFF_CMD, 32'h0000_0001);
    chk("init_clr", float_error_out_n, 1'b1);
    rd_reg(8'h40);
    chk("unmapped", rs, fpu_exc_pkg::RESP_SLVERR);
    wr(8'h40, 32'h0000_0000);
    chk("wr_unmapped", bs, fpu_exc_pkg::RESP_SLVERR);
  endtask
  initial begin
    #300000;
    err_count++;
    end_of_test;
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, ins_valid} = '0;
    {ins_push, ins_pop, ins_wr_top, ins_rd_en, ins_cc_response} = '0;
    {ins_arith_invalid, awaddr, araddr, wdata, ins_ip, rst_n} = '0;
    {ins_kind, ins_dst_fmt, ins_rd_idx, err_count, checked} = '0;
    wstrb = 4'hF;
    ignore_numeric_error_n = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    stack_overflow;
    operand_rules;
    native_trap;
    halt_mode;
    ignore_mode;
    end_of_test;
  end
endmodule
